// ==== hdl/seq_ctrl.v ====
// Sequencer control word, sequencing parameters, event flags and limit switch gating.
// Assumes a single AHB-Lite master, 100 MHz hclk and synchronous sequencer inputs.
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`include "seq_ctrl_regs.vh"

module seq_ctrl (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        closed_loop,
    input  wire        regen_mode,
    input  wire signed [31:0] pre_ramp_ref,
    input  wire signed [31:0] hard_speed_ref,
    input  wire        forward_limit_input,
    input  wire        reverse_limit_input,
    input  wire        defaults_saved,
    input  wire        mode_change_saved,
    input  wire        trip_clear_request,
    output reg         drive_enable,
    output reg         run_forward,
    output reg         jog_forward,
    output reg         run_reverse,
    output reg         direction_select,
    output reg         run,
    output reg         run_permit,
    output reg         jog_reverse,
    output reg         reference_source_select,
    output reg         drive_reset_pulse,
    output reg         watchdog_service_pulse,
    output reg         command_word_trip,
    output reg         forward_stop,
    output reg         reverse_stop,
    output wire        irq
);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    reg  [`PARAMS_W-1:0] params_q;
    reg  [15:0]          event_flags_q;
    reg  [`CW_W-1:0]     cmd_word_q;
    reg                  cmd_enable_q;
    reg  [`IRQ_W-1:0]    irq_status_q;
    reg  [`IRQ_W-1:0]    irq_mask_q;
    reg  [7:0]           addr_q;
    reg                  wr_q;
    reg  [21:0]          tick_cnt_q;
    reg                  tick_q;
    reg                  cw_ref_q;
    reg                  cw_reset_q;
    reg                  cw_wdog_q;
    reg                  latch_fwd_q;
    reg                  latch_rev_q;
    reg                  latch_run_q;
    reg                  fwd_arm;
    reg                  rev_arm;
    wire                 wr_now;
    wire                 ovr;
    wire                 ovr_seq;
    wire                 cw_live;
    wire signed [32:0]   speed_sum;
    wire [`IRQ_W-1:0]    irq_events;
    reg                  eff_en;
    reg                  eff_rf;
    reg                  eff_jf;
    reg                  eff_rr;
    reg                  eff_dir;
    reg                  eff_run;
    reg                  eff_np;
    reg                  eff_jr;

    // The slave never stalls, so every access completes with zero wait states.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_now    = wr_q;
    assign irq       = |(irq_status_q & irq_mask_q);

    // Capture the address phase of each valid transfer.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 8'h00;
            wr_q   <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            if (hsel && hready && htrans[1]) begin
                addr_q <= haddr;
                wr_q   <= hwrite;
            end
        end
    end

    // Read data is presented in the data phase; unmapped offsets read as zero.
    always @* begin
        hrdata = 32'h0000_0000;
        case (addr_q)
            `OFF_PARAMS:      hrdata = {23'h000000, params_q};
            `OFF_EVENT_FLAGS: hrdata = {16'h0000, event_flags_q};
            `OFF_CMD_WORD:    hrdata = {17'h00000, cmd_word_q};
            `OFF_CMD_ENABLE:  hrdata = {31'h00000000, cmd_enable_q};
            `OFF_STATUS:      hrdata = {23'h000000, command_word_trip, run_permit,
                                        latch_run_q, latch_rev_q, latch_fwd_q,
                                        fwd_arm, rev_arm, forward_stop, reverse_stop};
            `OFF_IRQ_STATUS:  hrdata = {29'h00000000, irq_status_q};
            `OFF_IRQ_MASK:    hrdata = {29'h00000000, irq_mask_q};
            default:          hrdata = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Registers and event flags
    // ****************************************************************
    assign irq_events = {command_word_trip == 1'b0 && cmd_enable_q && cmd_word_q[`CW_TRIP],
                         mode_change_saved, defaults_saved};

    // Hardware sets win over a software clear in the same cycle so no event is lost.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            params_q      <= 9'h000;
            event_flags_q <= 16'h0000;
            cmd_word_q    <= 15'h0000;
            cmd_enable_q  <= 1'b0;
            irq_status_q  <= 3'h0;
            irq_mask_q    <= 3'h0;
        end else begin
            if (wr_now && addr_q == `OFF_PARAMS)
                params_q <= hwdata[`PARAMS_W-1:0];
            if (wr_now && addr_q == `OFF_CMD_WORD)
                cmd_word_q <= hwdata[`CW_W-1:0] & `CW_WRITE_MASK;
            if (wr_now && addr_q == `OFF_CMD_ENABLE)
                cmd_enable_q <= hwdata[0];
            if (wr_now && addr_q == `OFF_IRQ_MASK)
                irq_mask_q <= hwdata[`IRQ_W-1:0];
            if (wr_now && addr_q == `OFF_EVENT_FLAGS)
                event_flags_q <= hwdata[15:0];
            if (defaults_saved)
                event_flags_q[`EV_DEFAULTS] <= 1'b1;
            if (mode_change_saved)
                event_flags_q[`EV_MODE_CHANGED] <= 1'b1;
            irq_status_q <= ((wr_now && addr_q == `OFF_IRQ_STATUS) ?
                             (irq_status_q & ~hwdata[`IRQ_W-1:0]) : irq_status_q)
                            | irq_events;
        end
    end

    // ****************************************************************
    // Sequencer tick
    // ****************************************************************
    // A 4 ms tick samples the sequencing bits; the upper command bits run every clock.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= 22'h000000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == `TICK_CYCLES - 1) begin
            tick_cnt_q <= 22'h000000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 22'h000001;
            tick_q     <= 1'b0;
        end
    end

    // ****************************************************************
    // Command word override
    // ****************************************************************
    assign cw_live = cmd_enable_q;
    assign ovr     = cw_live && cmd_word_q[`CW_AUTO];
    // Regen mode drops the run-type bits but keeps drive enable.
    assign ovr_seq = ovr && !regen_mode;

    // Each effective bit picks the command bit or its parameter.
    always @* begin
        eff_en  = ovr     ? cmd_word_q[0] : params_q[`PB_DRIVE_ENABLE];
        eff_rf  = ovr_seq ? cmd_word_q[1] : params_q[`PB_RUN_FWD];
        eff_jf  = ovr_seq ? cmd_word_q[2] : params_q[`PB_JOG_FWD];
        eff_rr  = ovr_seq ? cmd_word_q[3] : params_q[`PB_RUN_REV];
        eff_dir = ovr_seq ? cmd_word_q[4] : params_q[`PB_DIR_SEL];
        eff_run = ovr_seq ? cmd_word_q[5] : params_q[`PB_RUN];
        eff_np  = ovr_seq ? cmd_word_q[6] : params_q[`PB_RUN_PERMIT];
        eff_jr  = ovr_seq ? cmd_word_q[`CW_JOG_REV] : params_q[`PB_JOG_REV];
    end

    // Effective inputs and run latches update only on the tick.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_enable     <= 1'b0;
            run_forward      <= 1'b0;
            jog_forward      <= 1'b0;
            run_reverse      <= 1'b0;
            direction_select <= 1'b0;
            run              <= 1'b0;
            run_permit       <= 1'b0;
            jog_reverse      <= 1'b0;
            latch_fwd_q      <= 1'b0;
            latch_rev_q      <= 1'b0;
            latch_run_q      <= 1'b0;
        end else if (tick_q) begin
            drive_enable     <= eff_en;
            jog_forward      <= eff_jf;
            direction_select <= eff_dir;
            run_permit       <= eff_np;
            jog_reverse      <= eff_jr;
            if (!eff_np) begin
                latch_fwd_q <= 1'b0;
                latch_rev_q <= 1'b0;
                latch_run_q <= 1'b0;
            end else if (params_q[`PB_LATCH_EN]) begin
                latch_fwd_q <= latch_fwd_q | eff_rf;
                latch_rev_q <= latch_rev_q | eff_rr;
                latch_run_q <= latch_run_q | eff_run;
            end else begin
                latch_fwd_q <= 1'b0;
                latch_rev_q <= 1'b0;
                latch_run_q <= 1'b0;
            end
            run_forward <= eff_rf  | (params_q[`PB_LATCH_EN] & eff_np & latch_fwd_q);
            run_reverse <= eff_rr  | (params_q[`PB_LATCH_EN] & eff_np & latch_rev_q);
            run         <= eff_run | (params_q[`PB_LATCH_EN] & eff_np & latch_run_q);
        end
    end

    // ****************************************************************
    // Upper command bits: reference, reset, watchdog, trip
    // ****************************************************************
    // Rising edges of reset and watchdog bits give one-cycle pulses.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cw_ref_q                <= 1'b0;
            cw_reset_q              <= 1'b0;
            cw_wdog_q               <= 1'b0;
            reference_source_select <= 1'b0;
            drive_reset_pulse       <= 1'b0;
            watchdog_service_pulse  <= 1'b0;
            command_word_trip       <= 1'b0;
        end else begin
            cw_ref_q   <= cw_live && cmd_word_q[`CW_REF_SEL] && !regen_mode;
            cw_reset_q <= cw_live && cmd_word_q[`CW_RESET];
            cw_wdog_q  <= cw_live && cmd_word_q[`CW_WDOG];
            reference_source_select <= cw_ref_q;
            drive_reset_pulse       <= cw_live && cmd_word_q[`CW_RESET] && !cw_reset_q;
            watchdog_service_pulse  <= cw_live && cmd_word_q[`CW_WDOG] && !cw_wdog_q;
            // The trip holds while bit 12 stays set and the command word is enabled, whatever clears are asked.
            if (cw_live && cmd_word_q[`CW_TRIP])
                command_word_trip <= 1'b1;
            else if (trip_clear_request || drive_reset_pulse)
                command_word_trip <= 1'b0;
        end
    end

    // ****************************************************************
    // Limit switch gating
    // ****************************************************************
    assign speed_sum = {pre_ramp_ref[31], pre_ramp_ref} + {hard_speed_ref[31], hard_speed_ref};

    // Closed loop includes the hard reference; open loop uses pre-ramp alone.
    always @* begin
        if (closed_loop) begin
            fwd_arm = speed_sum >= 0;
            rev_arm = speed_sum <= 0;
        end else begin
            fwd_arm = pre_ramp_ref >= 0;
            rev_arm = pre_ramp_ref <= 0;
        end
    end

    // A stop acts only in its own direction so the load can back off the limit.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            forward_stop <= 1'b0;
            reverse_stop <= 1'b0;
        end else begin
            forward_stop <= fwd_arm && forward_limit_input;
            reverse_stop <= rev_arm && reverse_limit_input;
        end
    end

endmodule // seq_ctrl

// ==== hdl/seq_ctrl_regs.vh ====
// Register map, field positions, write mask and timing counts of the sequencer control block.
// Assumes byte addressing on a 32-bit AHB-Lite data bus, one register per aligned word.
`ifndef SEQ_CTRL_REGS_VH
`define SEQ_CTRL_REGS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFF_PARAMS        8'h00
`define OFF_EVENT_FLAGS   8'h04
`define OFF_CMD_WORD      8'h08
`define OFF_CMD_ENABLE    8'h0c
`define OFF_STATUS        8'h10
`define OFF_IRQ_STATUS    8'h14
`define OFF_IRQ_MASK      8'h18

// ****************************************************************
// Parameter register fields
// ****************************************************************
`define PB_DRIVE_ENABLE   0
`define PB_RUN_FWD        1
`define PB_JOG_FWD        2
`define PB_RUN_REV        3
`define PB_DIR_SEL        4
`define PB_RUN            5
`define PB_RUN_PERMIT     6
`define PB_JOG_REV        7
`define PB_LATCH_EN       8
`define PARAMS_W          9

// ****************************************************************
// Command word fields
// ****************************************************************
`define CW_AUTO           7
`define CW_REF_SEL        8
`define CW_JOG_REV        9
`define CW_TRIP           12
`define CW_RESET          13
`define CW_WDOG           14
`define CW_W              15
`define CW_WRITE_MASK     15'h73ff

// ****************************************************************
// Event flags and interrupt status fields
// ****************************************************************
`define EV_DEFAULTS       0
`define EV_MODE_CHANGED   1
`define IRQ_TRIP          2
`define IRQ_W             3

// ****************************************************************
// Timing
// ****************************************************************
`define TICK_MS           4
`define CLK_MHZ           100
`define TICK_CYCLES       (`TICK_MS * 1000 * `CLK_MHZ)

`endif

// ==== verif/seq_ctrl_properties.sv ====
// Concurrent checks on the ports of the sequencer control block, bound to every instance.
// Assumes one clock domain, hclk, with the asynchronous active-low reset hresetn.
`timescale 1ns/1ps
module seq_ctrl_properties (
    input logic               hclk,
    input logic               hresetn,
    input logic               hreadyout,
    input logic               hresp,
    input logic               closed_loop,
    input logic signed [31:0] pre_ramp_ref,
    input logic signed [31:0] hard_speed_ref,
    input logic               forward_limit_input,
    input logic               reverse_limit_input,
    input logic               trip_clear_request,
    input logic               drive_reset_pulse,
    input logic               watchdog_service_pulse,
    input logic               command_word_trip,
    input logic               forward_stop,
    input logic               reverse_stop,
    input logic               irq
);
    // ****************************************************************
    // Limit arming model
    // ****************************************************************
    // Speed demand held in 33 bits so that the closed-loop sum cannot wrap.
    wire signed [32:0] spd = closed_loop ? pre_ramp_ref + hard_speed_ref : pre_ramp_ref;
    wire               fwd_d = forward_limit_input & ~spd[32];
    wire               rev_d = reverse_limit_input & (spd[32] | (spd == 33'sh0));

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // A request pulse lasts exactly one cycle.
    sequence lone_rst;
        drive_reset_pulse ##1 !drive_reset_pulse;
    endsequence
    sequence lone_wdog;
        watchdog_service_pulse ##1 !watchdog_service_pulse;
    endsequence

    bus_okay_a:
        assert property (hreadyout && !hresp) else $error("Bus answer is not a zero-wait okay.");
    fwd_stop_a:
        assert property (1'h1 |=> forward_stop == $past(fwd_d)) else $error("Forward stop wrong.");
    rev_stop_a:
        assert property (1'h1 |=> reverse_stop == $past(rev_d)) else $error("Reverse stop wrong.");
    both_armed_a:
        assert property ((&{forward_limit_input, reverse_limit_input}) && pre_ramp_ref == 32'sh0
            && hard_speed_ref == 32'sh0 |=> forward_stop && reverse_stop) else $error("Zero arm.");
    trip_hold_a:
        assert property (command_word_trip && !trip_clear_request && !drive_reset_pulse
            |=> command_word_trip)
            else $error("Trip dropped without a clear request.");
    rst_pulse_a:
        assert property (drive_reset_pulse |-> lone_rst) else $error("Reset pulse too long.");
    wdog_pulse_a:
        assert property (watchdog_service_pulse |-> lone_wdog) else $error("Service pulse long.");
    reset_clear_a:
        assert property ($rose(hresetn) |-> !(forward_stop || reverse_stop || command_word_trip
            || drive_reset_pulse || watchdog_service_pulse || irq)) else $error("Not reset.");
endmodule // seq_ctrl_properties

bind seq_ctrl seq_ctrl_properties i_props (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .closed_loop(closed_loop), .pre_ramp_ref(pre_ramp_ref), .hard_speed_ref(hard_speed_ref),
    .forward_limit_input(forward_limit_input), .reverse_limit_input(reverse_limit_input),
    .trip_clear_request(trip_clear_request), .drive_reset_pulse(drive_reset_pulse),
    .watchdog_service_pulse(watchdog_service_pulse), .command_word_trip(command_word_trip),
    .forward_stop(forward_stop), .reverse_stop(reverse_stop), .irq(irq)
);

// ==== verif/seq_ctrl_tb_top.sv ====
// Self-checking bench for the sequencer control block.
// Assumes the design files and the register header are on the include path.
`timescale 1ns/1ps
`include "seq_ctrl_regs.vh"
module seq_ctrl_tb_top;
    logic               hclk = 1'h0;
    logic               hresetn = 1'h0;
    logic               closed_loop = 1'h0;
    logic               regen_mode = 1'h0;
    logic signed [31:0] pre_ramp_ref = 32'sh0;
    logic signed [31:0] hard_speed_ref = 32'sh0;
    logic [1:0]         lim = 2'h0;
    logic [2:0]         ev = 3'h0;
    wire                hsel, hwrite, hreadyout, hresp, irq, ref_sel, rst_p, wd_p, trip;
    wire                f_stop, r_stop;
    wire [7:0]          haddr, seq_o;
    wire [1:0]          htrans;
    wire [2:0]          hsize;
    wire [31:0]         hwdata, hrdata;
    logic [31:0]        exp_q[$];
    logic               rd_dp = 1'h0;
    int                 n_errors = 0, cmp_count = 0, cyc = 0, n_rst = 0, n_wd = 0;

    // ****************************************************************
    // Design, host model and monitors
    // ****************************************************************
    seq_host i_host (.hclk(hclk), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    seq_ctrl i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .closed_loop(closed_loop),
        .regen_mode(regen_mode), .pre_ramp_ref(pre_ramp_ref), .hard_speed_ref(hard_speed_ref),
        .forward_limit_input(lim[0]), .reverse_limit_input(lim[1]), .defaults_saved(ev[0]),
        .mode_change_saved(ev[1]), .trip_clear_request(ev[2]), .drive_enable(seq_o[0]),
        .run_forward(seq_o[1]), .jog_forward(seq_o[2]), .run_reverse(seq_o[3]),
        .direction_select(seq_o[4]), .run(seq_o[5]), .run_permit(seq_o[6]),
        .jog_reverse(seq_o[7]), .reference_source_select(ref_sel), .drive_reset_pulse(rst_p),
        .watchdog_service_pulse(wd_p), .command_word_trip(trip), .forward_stop(f_stop),
        .reverse_stop(r_stop), .irq(irq));

    // Free-running 100 MHz clock.
    always #5 hclk = ~hclk;

    // Read data phases are spotted on the bus; the oldest note is checked mid-cycle.
    always @(posedge hclk) rd_dp <= hsel && hreadyout && htrans[1] && !hwrite;
    always @(negedge hclk) if (rd_dp) chk(hrdata, exp_q.pop_front());

    // Pulses are counted so that a doubled or missing one is seen later.
    always @(posedge hclk) begin
        n_rst <= n_rst + int'(rst_p);
        n_wd <= n_wd + int'(wd_p);
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'h1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        i_host.xfer(1'h0, a, 32'h0);
    endtask

    // Pins are looked at mid-cycle, after the edge's updates have landed.
    task automatic look(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic pulse(input logic [2:0] v);
        @(posedge hclk);
        ev <= v;
        @(posedge hclk);
        ev <= 3'h0;
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [2:0] s;
        int         p, h, v;
        void'($urandom(58));
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        for (int a = 0; a < 32; a += 4) rd(8'(a), a == 16 ? 32'hc : 32'h0);
        wr(`OFF_PARAMS, 32'hffff_ffff);
        rd(`OFF_PARAMS, 32'h1ff);
        look(1);
        chk(seq_o, 8'h0);
        wr(`OFF_CMD_WORD, 32'hffff_cfff);
        rd(`OFF_CMD_WORD, 32'h43ff);
        look(2);
        chk({ref_sel, trip}, 2'h0);
        @(posedge hclk);
        regen_mode <= 1'h1;
        wr(`OFF_CMD_ENABLE, 32'h1);
        look(2);
        chk({ref_sel, trip}, 2'h0);
        wr(`OFF_CMD_WORD, 32'hffff_ffff);
        look(3);
        chk(32'(n_rst * 16 + n_wd), 32'h11);
        @(posedge hclk);
        regen_mode <= 1'h0;
        look(2);
        chk(ref_sel, 1'h1);
        pulse(3'h4);
        look(1);
        chk(trip, 1'h1);
        wr(`OFF_CMD_WORD, 32'h0);
        pulse(3'h4);
        look(1);
        chk(trip, 1'h0);
        wr(`OFF_CMD_ENABLE, 32'h0);
        rd(`OFF_IRQ_STATUS, 32'h4);
        wr(`OFF_IRQ_STATUS, 32'h7);
        pulse(3'h1);
        rd(`OFF_EVENT_FLAGS, 32'h1);
        rd(`OFF_IRQ_STATUS, 32'h1);
        look(0);
        chk(irq, 1'h0);
        wr(`OFF_IRQ_MASK, 32'h1);
        look(0);
        chk(irq, 1'h1);
        pulse(3'h2);
        rd(`OFF_EVENT_FLAGS, 32'h3);
        wr(`OFF_EVENT_FLAGS, 32'h0);
        rd(`OFF_EVENT_FLAGS, 32'h0);
        wr(`OFF_IRQ_STATUS, 32'h1);
        rd(`OFF_IRQ_STATUS, 32'h2);
        look(0);
        chk(irq, 1'h0);
        // Random speed demands around zero, with limit patterns and loop modes drawn at random over 24 passes.
        for (int i = 0; i < 24; i++) begin
            s = 3'($urandom);
            p = int'($urandom_range(6)) - 3;
            h = int'($urandom_range(6)) - 3;
            @(posedge hclk);
            closed_loop <= s[0];
            lim <= s[2:1];
            pre_ramp_ref <= p;
            hard_speed_ref <= h;
            repeat (2) @(posedge hclk);
            v = s[0] ? p + h : p;
            rd(`OFF_STATUS, {28'h0, v >= 0, v <= 0, v >= 0 && s[1], v <= 0 && s[2]});
        end
        look(2);
        wrap_up();
    end
endmodule // seq_ctrl_tb_top

// ==== verif/seq_host.sv ====
// Bus master model standing in for the host software that writes drive parameters.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module seq_host (
    input  logic        hclk,
    input  logic        hready,
    output logic        hsel,
    output logic [7:0]  haddr,
    output logic [1:0]  htrans,
    output logic        hwrite,
    output logic [2:0]  hsize,
    output logic [31:0] hwdata
);
    // Idle bus from time zero; only whole words are ever moved.
    initial begin
        hsel = 1'h1;
        haddr = 8'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // One single transfer; each phase is held until hready is seen high at an edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (hclk == 1'h0) @(posedge hclk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= w ? d : ~hwdata;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
    endtask
endmodule // seq_host
